// ===== core/sideband_ctrl.sv
// sideband control and status logic of the pluggable module
`timescale 1ns/100ps
`default_nettype none
`include "sideband_consts.svh"
// How it works
// RL1: seven low-speed pins including serial clock, data
// RL2: answer the serial bus only while selected
// RL3: host gives each module its own select
// RL4: reset held past minimum restores all defaults
// RL5: host ignores status until reset completion
// RL6: completion shown by attention with ready status
// RL7: completion posted after power-up without reset
// RL8: low-power input limits maximum power
// RL9: present line pulled low by inserted module
// RL10: attention pulled low for fault or critical status
// RL11: host reads status to find attention cause
// RL12: attention held until latched flags read
module sideband_ctrl
	import sideband_pkg::*;
#(
	parameter int unsigned INIT_CYC = `INIT_CYC
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic low_power_select,
	input wire logic fault_event,
	output logic module_present_out,
	output logic module_present_oe,
	output logic attention_out,
	output logic attention_oe,
	output logic power_limit,
	output logic module_in_reset
);
	logic rst_meta;
	logic rst_n;
	logic [3:0] pin_raw;
	logic [3:0] s1;
	logic [3:0] s2;
	logic [3:0] s3;
	logic [3:0] agreed;
	logic [3:0] next_agreed;
	logic status_sent;
	logic clr_pulse;
	core_state_e state;
	core_state_e next_state;
	logic [31:0] low_cnt;
	logic [31:0] next_low_cnt;
	logic [31:0] init_cnt;
	logic [31:0] next_init_cnt;
	logic [1:0] flags;
	logic [1:0] next_flags;
	logic [7:0] status_word;
	logic [7:0] next_status_word;
	logic next_attention_oe;
	logic next_power_limit;
	logic next_module_in_reset;
	// power limit and select come up at their safe idle levels
	localparam logic [3:0] SYNC_INIT = `SYNC_RESET_VAL;

	// reset release through two flops
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// serial link runs on its own clock; only select clears it
	link_port u_link ( // RL1
		.scl(scl),
		.module_select_n(module_select_n),
		.sda_in(sda_in),
		.status_word(status_word),
		.sda_oe(sda_oe),
		.status_sent(status_sent)
	);

	assign pin_raw = {status_sent, low_power_select, module_reset_n, module_select_n};

	// three-stage capture; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_comb
			begin
				next_agreed[gi] = (s2[gi] == s3[gi]) ? s3[gi] : agreed[gi];
			end
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					s1[gi] <= SYNC_INIT[gi];
					s2[gi] <= SYNC_INIT[gi];
					s3[gi] <= SYNC_INIT[gi];
					agreed[gi] <= SYNC_INIT[gi];
				end
				else
				begin
					s1[gi] <= pin_raw[gi];
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					agreed[gi] <= next_agreed[gi];
				end
			end
		end
	endgenerate

	// host finished reading the status byte
	assign clr_pulse = next_agreed[`SYNC_SENT] && !agreed[`SYNC_SENT];

	// reset, initialisation and ready sequencing
	always_comb
	begin
		next_state = state;
		next_low_cnt = low_cnt;
		next_init_cnt = init_cnt;
		if (agreed[`SYNC_RST])
			next_low_cnt = 32'h0;
		else if (low_cnt < `RESET_MIN_CYC)
			next_low_cnt = low_cnt + 32'h1;
		case (state)
			ST_RESET:
			begin
				next_init_cnt = 32'h0;
				if (agreed[`SYNC_RST])
					next_state = ST_INIT;
			end
			ST_INIT:
			begin
				next_init_cnt = init_cnt + 32'h1;
				if (init_cnt >= INIT_CYC - 1)
					next_state = ST_READY;
			end
			default: next_state = ST_READY;
		endcase
		// short glitches on the reset pin are ignored
		if (!agreed[`SYNC_RST] && low_cnt == `RESET_MIN_CYC) // RL4
			next_state = ST_RESET;
	end

	// latched flags: a new event wins over a clear in the same cycle
	always_comb
	begin
		next_flags = flags;
		if (clr_pulse)
			next_flags = flags & ~status_word[1:0]; // RL12
		if (fault_event)
			next_flags[`STAT_FAULT] = 1'b1; // RL10
		if (state == ST_INIT && next_state == ST_READY)
			next_flags[`STAT_DONE] = 1'b1; // RL7
		if (next_state == ST_RESET)
			next_flags = 2'b00; // RL4
		next_status_word = status_word;
		// frozen while selected so the link reads a stable word
		if (next_agreed[`SYNC_SEL])
		begin
			next_status_word = 8'h00;
			next_status_word[`STAT_NOT_READY] = (next_state != ST_READY); // RL6
			next_status_word[1:0] = next_flags;
		end
		next_attention_oe = |next_flags; // RL10
		next_power_limit = next_agreed[`SYNC_LP]; // RL8
		next_module_in_reset = (next_state != ST_READY); // RL4
	end

	// sequencing state
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_INIT; // RL7
			low_cnt <= 32'h0;
			init_cnt <= 32'h0;
		end
		else
		begin
			state <= next_state;
			low_cnt <= next_low_cnt;
			init_cnt <= next_init_cnt;
		end
	end

	// latched flags and the word the link reads
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags <= 2'b00;
			status_word <= `STATUS_RESET_VAL;
		end
		else
		begin
			flags <= next_flags;
			status_word <= next_status_word;
		end
	end

	// pin outputs, all registered; open-drain values stay at zero
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			attention_oe <= 1'b0;
			attention_out <= 1'b0;
			power_limit <= 1'b1;
			module_in_reset <= 1'b1;
			module_present_out <= 1'b0;
			module_present_oe <= 1'b1;
			sda_out <= 1'b0;
		end
		else
		begin
			attention_oe <= next_attention_oe;
			attention_out <= 1'b0;
			power_limit <= next_power_limit;
			module_in_reset <= next_module_in_reset;
			module_present_out <= 1'b0; // RL9
			module_present_oe <= 1'b1; // RL9
			sda_out <= 1'b0;
		end
	end

	AST_PRESENT_LOW: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
		module_present_oe && !module_present_out)
		else $error("present line not pulled low");
	AST_LONG_RESET: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		(!agreed[`SYNC_RST] && low_cnt == `RESET_MIN_CYC) |=> (state == ST_RESET && flags == 2'b00))
		else $error("held reset did not restore defaults");
	AST_DONE_POST: assert property (@(posedge core_clk) disable iff (!rst_n) // RL6
		(state == ST_INIT ##1 state == ST_READY) |-> (attention_oe && flags[`STAT_DONE]
			&& !module_in_reset))
		else $error("reset completion not posted");
	AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
		(attention_oe && !clr_pulse && next_state != ST_RESET) |=> attention_oe)
		else $error("attention released before flags read");
	AST_RELEASE: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
		(clr_pulse && flags == status_word[1:0] && !fault_event
			&& !(state == ST_INIT && next_state == ST_READY)) |=> !attention_oe)
		else $error("attention not released after read");
	AST_LOW_POWER: assert property (@(posedge core_clk) disable iff (!rst_n) // RL8
		(s2[`SYNC_LP] == s3[`SYNC_LP] && s3[`SYNC_LP] != power_limit)
		|=> power_limit == $past(s3[`SYNC_LP]))
		else $error("power limit does not follow low-power input");

	// sequencing, flags, open-drain values and the frozen status word
	AST_IN_RESET_OUT: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		module_in_reset == (state != ST_READY))
		else $error("reset output disagrees with sequencing state");

	AST_RESET_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		(state == ST_RESET) |-> (!attention_oe && flags == 2'b00 && module_in_reset))
		else $error("flags or attention survive a module reset");

	AST_LOW_CNT_CAP: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		(low_cnt <= `RESET_MIN_CYC))
		else $error("reset pulse counter ran past its limit");

	AST_GLITCH_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		(state == ST_READY && low_cnt != `RESET_MIN_CYC) |=> state == ST_READY)
		else $error("short reset pulse left the ready state");

	AST_INIT_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7
		(state == ST_INIT && init_cnt < INIT_CYC - 1 && low_cnt != `RESET_MIN_CYC)
		|=> state == ST_INIT)
		else $error("initialisation ended early");

	AST_DONE_AT_READY: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7
		$rose(flags[`STAT_DONE]) |-> (state == ST_READY && $past(state) == ST_INIT))
		else $error("completion flag set outside the end of initialisation");

	AST_FAULT_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
		(fault_event && next_state != ST_RESET) |=> (flags[`STAT_FAULT] && attention_oe))
		else $error("fault event not latched onto attention");

	AST_ATT_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
		attention_oe == (flags != 2'b00))
		else $error("attention does not match the latched flags");

	AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
		!attention_out && !sda_out)
		else $error("open-drain output value not low");

	AST_STATUS_READY: assert property (@(posedge core_clk) disable iff (!rst_n) // RL6
		agreed[`SYNC_SEL] |-> (status_word[`STAT_NOT_READY] == module_in_reset
			&& status_word[1:0] == flags))
		else $error("status word stale while deselected");

	AST_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
		!next_agreed[`SYNC_SEL] |=> $stable(status_word))
		else $error("status word moved while the link may read it");

	AST_UNREAD_KEPT: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
		(flags[`STAT_FAULT] && !status_word[`STAT_FAULT] && next_state != ST_RESET)
		|=> flags[`STAT_FAULT])
		else $error("unread fault flag was cleared");
endmodule : sideband_ctrl
`default_nettype wire

// ===== core/sideband_consts.svh
// timing counts, field positions and reset values of the sideband control block
`ifndef SIDEBAND_CONSTS_SVH
`define SIDEBAND_CONSTS_SVH
`define CORE_CLK_PERIOD_NS 40
`define RESET_MIN_NS 10000
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define INIT_TIME_US 300000
`define INIT_CYC ((`INIT_TIME_US * 1000) / `CORE_CLK_PERIOD_NS)
`define DEV_ADDR 7'h50
`define STAT_NOT_READY 7
`define STAT_FAULT 1
`define STAT_DONE 0
`define SYNC_SEL 0
`define SYNC_RST 1
`define SYNC_LP 2
`define SYNC_SENT 3
`define SYNC_RESET_VAL 4'hf
`define STATUS_RESET_VAL 8'h80
`endif

// ===== core/sideband_pkg.sv
// state types of the sideband control block
package sideband_pkg;
	typedef enum logic [1:0] {ST_RESET, ST_INIT, ST_READY} core_state_e;
	typedef enum logic [2:0] {LK_ADDR, LK_ACK, LK_SEND, LK_HOSTACK, LK_IGNORE} link_state_e;
endpackage : sideband_pkg

// ===== core/link_port.sv
// two-wire serial link logic clocked by the serial clock
`timescale 1ns/100ps
`default_nettype none
`include "sideband_consts.svh"
module link_port
	import sideband_pkg::*;
(
	input wire logic scl,
	input wire logic module_select_n,
	input wire logic sda_in,
	input wire logic [7:0] status_word,
	output logic sda_oe,
	output logic status_sent
);
	link_state_e state;
	link_state_e next_state;
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic [6:0] addr_sh;
	logic [6:0] next_addr_sh;
	logic [7:0] tx;
	logic [7:0] next_tx;
	logic next_status_sent;
	logic next_sda_oe;

	// select high holds everything cleared, so a deselected module never drives
	always_comb
	begin
		next_state = state;
		next_cnt = cnt + 3'h1;
		next_addr_sh = addr_sh;
		next_tx = tx;
		next_status_sent = status_sent;
		case (state)
			LK_ADDR:
			begin
				next_addr_sh = {addr_sh[5:0], sda_in};
				if (cnt == 3'h7)
				begin
					// status word is frozen by the core while select is low
					next_tx = status_word;
					next_cnt = 3'h0;
					if (addr_sh == `DEV_ADDR && sda_in) // RL2
						next_state = LK_ACK;
					else
						next_state = LK_IGNORE;
				end
			end
			LK_ACK:
			begin
				next_cnt = 3'h0;
				next_state = LK_SEND;
			end
			LK_SEND:
			begin
				next_tx = {tx[6:0], 1'b0};
				if (cnt == 3'h7)
				begin
					next_state = LK_HOSTACK;
					next_status_sent = 1'b1; // RL12
				end
			end
			LK_HOSTACK: next_state = LK_IGNORE;
			default: next_state = LK_IGNORE;
		endcase
	end

	always_ff @(posedge scl or posedge module_select_n)
	begin
		if (module_select_n) // RL2
		begin
			state <= LK_ADDR;
			cnt <= 3'h0;
			addr_sh <= 7'h00;
			tx <= 8'h00;
			status_sent <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			addr_sh <= next_addr_sh;
			tx <= next_tx;
			status_sent <= next_status_sent;
		end
	end

	// data changes only while the clock is low
	always_comb
	begin
		next_sda_oe = (state == LK_ACK) || (state == LK_SEND && !tx[7]); // RL2
	end

	always_ff @(negedge scl or posedge module_select_n)
	begin
		if (module_select_n)
			sda_oe <= 1'b0;
		else
			sda_oe <= next_sda_oe;
	end

	AST_IGNORE_QUIET: assert property (@(posedge scl) disable iff (module_select_n) // RL2
		(state == LK_IGNORE && $past(state) == LK_IGNORE) |-> !sda_oe)
		else $error("link drives data while ignoring the bus");
	AST_ADDR_MISS: assert property (@(posedge scl) disable iff (module_select_n) // RL2
		(state == LK_ADDR && cnt == 3'h7 && addr_sh != `DEV_ADDR) |=> state == LK_IGNORE)
		else $error("foreign address not ignored");
	AST_ACK_DRIVEN: assert property (@(posedge scl) disable iff (module_select_n) // RL2
		(state == LK_ACK) |-> sda_oe)
		else $error("address acknowledge not driven");
endmodule : link_port
`default_nettype wire

// ===== tb/host_model.sv
// host board side of the sideband pins: select and serial clock driver
`timescale 1ns/100ps
`default_nettype none
module host_model
(
	input wire logic sda_oe,
	output logic scl,
	output logic module_select_n,
	output var logic sda_in
);
	logic host_low;
	// board pull-up: a released data wire reads high, never the last value
	assign sda_in = ~(host_low | sda_oe);
	initial
	begin
		scl = 1'b0;
		module_select_n = 1'b1;
		host_low = 1'b0;
	end
	// one read per frame; clock only runs inside the frame
	task automatic read_frame(input logic [7:0] head, output logic ack, output logic [7:0] data);
		int i;
		module_select_n = 1'b0;
		#200;
		for (i = 0; i < 18; i++)
		begin
			host_low = (i < 8) ? ~head[7 - i] : (i == 17);
			#15 scl = 1'b1;
			if (i == 8)
				ack = ~sda_in;
			if (i > 8 && i < 17)
				data[16 - i] = sda_in;
			#15 scl = 1'b0;
		end
		host_low = 1'b0;
		#200 module_select_n = 1'b1;
		#200;
	endtask : read_frame
endmodule : host_model
`default_nettype wire

// ===== tb/tb.sv
// self-checking testbench of the sideband control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
	logic core_clk, arst_n, module_reset_n, low_power_select, fault_event;
	logic scl, sda_in, module_select_n, sda_out, sda_oe, power_limit, module_in_reset;
	logic present_out, present_oe, attention_out, attention_oe, attention_n, module_present_n;
	int n_errors, comparisons;
	assign attention_n = attention_oe ? attention_out : 1'b1;
	assign module_present_n = present_oe ? present_out : 1'b1;
	sideband_ctrl #(.INIT_CYC(20)) DUT (
		.core_clk(core_clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
		.module_reset_n(module_reset_n), .low_power_select(low_power_select),
		.fault_event(fault_event), .module_present_out(present_out),
		.module_present_oe(present_oe), .attention_out(attention_out),
		.attention_oe(attention_oe), .power_limit(power_limit),
		.module_in_reset(module_in_reset)
	);
	host_model host (.sda_oe(sda_oe), .scl(scl), .module_select_n(module_select_n),
		.sda_in(sda_in));
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (module_select_n === 1'b1)
			`CHK(sda_oe, 1'b0)
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	// bounded wait for the attention line
	task automatic wait_att(input logic v);
		int i;
		for (i = 0; i < 400 && attention_oe !== v; i++)
			cyc(1);
	endtask : wait_att
	task automatic read_chk(input logic [7:0] want);
		logic ack;
		logic [7:0] d;
		host.read_frame(8'ha1, ack, d);
		`CHK(ack, 1'b1)
		`CHK(d, want)
		`CHK(sda_out, 1'b0)
	endtask : read_chk
	task automatic t_power_up;
		`CHK(module_present_n, 1'b0)
		`CHK(module_in_reset, 1'b1)
		cyc(4);
		`CHK(power_limit, 1'b1)
		wait_att(1'b1);
		`CHK(attention_n, 1'b0)
		`CHK(module_in_reset, 1'b0)
		read_chk(8'h01);
		cyc(10);
		`CHK(attention_n, 1'b1)
		$display("test power_up done");
	endtask : t_power_up
	task automatic t_wrong_frame;
		logic ack;
		logic [7:0] d;
		host.read_frame(8'ha3, ack, d);
		`CHK(ack, 1'b0)
		`CHK(d, 8'hff)
		host.read_frame(8'ha0, ack, d);
		`CHK(ack, 1'b0)
		$display("test wrong_frame done");
	endtask : t_wrong_frame
	task automatic t_fault;
		// fault lands after the word was frozen, so this read must not clear it
		fork
			read_chk(8'h00);
			begin
				cyc(12);
				@(posedge core_clk) fault_event <= 1'b1;
				@(posedge core_clk) fault_event <= 1'b0;
			end
		join
		cyc(2);
		`CHK(attention_n, 1'b0)
		@(posedge core_clk) fault_event <= 1'b1;
		@(posedge core_clk) fault_event <= 1'b0;
		cyc(2);
		`CHK(attention_n, 1'b0)
		cyc(50);
		`CHK(attention_n, 1'b0)
		read_chk(8'h02);
		cyc(10);
		`CHK(attention_n, 1'b1)
		$display("test fault done");
	endtask : t_fault
	task automatic t_short_reset;
		@(posedge core_clk) module_reset_n <= 1'b0;
		cyc(240);
		@(posedge core_clk) module_reset_n <= 1'b1;
		cyc(10);
		`CHK(module_in_reset, 1'b0)
		$display("test short_reset done");
	endtask : t_short_reset
	task automatic t_long_reset;
		@(posedge core_clk) module_reset_n <= 1'b0;
		cyc(262);
		`CHK(module_in_reset, 1'b1)
		`CHK(attention_n, 1'b1)
		read_chk(8'h80);
		@(posedge core_clk) module_reset_n <= 1'b1;
		// status trusted only once completion is posted
		wait_att(1'b1);
		`CHK(module_in_reset, 1'b0)
		read_chk(8'h01);
		cyc(10);
		`CHK(attention_n, 1'b1)
		$display("test long_reset done");
	endtask : t_long_reset
	task automatic t_low_power;
		@(posedge core_clk) low_power_select <= 1'b0;
		cyc(8);
		`CHK(power_limit, 1'b0)
		@(posedge core_clk) low_power_select <= 1'b1;
		cyc(8);
		`CHK(power_limit, 1'b1)
		$display("test low_power done");
	endtask : t_low_power
	task automatic complete_run;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	initial
	begin
		#300000;
		n_errors++;
		complete_run();
	end
	initial
	begin
		arst_n = 1'b0;
		module_reset_n = 1'b1;
		low_power_select = 1'b1;
		fault_event = 1'b0;
		cyc(10);
		`CHK(attention_n, 1'b1)
		`CHK(power_limit, 1'b1)
		@(posedge core_clk) arst_n <= 1'b1;
		cyc(1);
		t_power_up();
		t_wrong_frame();
		t_fault();
		t_short_reset();
		t_long_reset();
		t_low_power();
		complete_run();
	end
endmodule : tb
`undef CHK
`default_nettype wire
